//--- tb.sv
// Bench of the watchdog registers, overflow and refusals
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH %0t got %h want %h", $time, a, e); end end
module tb;
  reg         mclk = 1'b0, nrst = 1'b0, opt_nonstop = 1'b1, stop_mode = 1'b0;
  reg  [15:0] bus_addr = 16'h0000;
  reg  [7:0]  bus_wdata = 8'h00;
  reg         bus_wr = 1'b0, bus_bit_op = 1'b0, bus_rd = 1'b0, halt_mode = 1'b0;
  wire        low_speed_tick, sys_tick, wdt_reset_req;
  wire [7:0]  bus_rdata;
  integer     bad_count = 0, checked = 0;
  always #5 mclk = ~mclk;
  wdtc_tick_src #(.HALF(4)) i_slow (.mclk(mclk), .tick(low_speed_tick));
  wdtc_tick_src #(.HALF(3)) i_sys (.mclk(mclk), .tick(sys_tick));
  wdtc_watchdog i_dut (.mclk(mclk), .nrst(nrst), .opt_nonstop(opt_nonstop),
    .low_speed_tick(low_speed_tick), .sys_tick(sys_tick), .halt_mode(halt_mode),
    .stop_mode(stop_mode), .osc_stable(1'b1), .xtal_osc(1'b0), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_bit_op(bus_bit_op), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .wdt_reset_req(wdt_reset_req));
  task wr(input [15:0] a, input [7:0] d, input bo, input e);
    begin
      @(posedge mclk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_bit_op <= bo;
      bus_wr <= 1'b1;
      @(posedge mclk);
      bus_wr <= 1'b0;
      #1 `CHK(wdt_reset_req, e)
    end
  endtask
  task rd(input [15:0] a, input [7:0] e);
    begin
      @(posedge mclk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge mclk);
      bus_rd <= 1'b0;
      #1 `CHK(bus_rdata, e)
    end
  endtask
  task start(input mode);
    begin
      @(posedge mclk);
      nrst <= 1'b0;
      opt_nonstop <= mode;
      repeat (20) @(posedge mclk);
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
    end
  endtask
  // Overflow of period 0 on the slow tick: 2048 ticks of 8 cycles each
  task wait_ovf(input integer lo, input integer hi);
    integer n;
    begin
      n = 0;
      while (wdt_reset_req !== 1'b1 && n < 25000) begin
        @(posedge mclk);
        #1 n = n + 1;
      end
      `CHK(n > lo && n < hi, 1'b1)
    end
  endtask
  task complete_run;
    begin
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    #800000;
    bad_count++;
    complete_run;
  end
  initial begin
    start(1'b1);
    rd(16'hff48, 8'h67);
    rd(16'hff49, 8'h9a);
    wr(16'hff48, 8'h78, 1'b0, 1'b0);
    @(posedge mclk) stop_mode <= 1'b1;
    rd(16'hff48, 8'h60);
    wait_ovf(16300, 16500);
    repeat (8000) @(posedge mclk);
    wr(16'hff49, 8'hac, 1'b0, 1'b0);
    wait_ovf(16300, 16500);
    @(posedge mclk) stop_mode <= 1'b0;
    wr(16'hff48, 8'h67, 1'b0, 1'b1);
    wr(16'hff49, 8'h00, 1'b0, 1'b1);
    wr(16'hff49, 8'hac, 1'b1, 1'b1);
    $display("non-stoppable test done");
    start(1'b0);
    wr(16'hff48, 8'h70, 1'b0, 1'b0);
    rd(16'hff48, 8'h70);
    wr(16'hff48, 8'h67, 1'b0, 1'b0);
    wr(16'hff49, 8'h12, 1'b0, 1'b0);
    wr(16'hff49, 8'hac, 1'b1, 1'b0);
    $display("stoppable test done");
    start(1'b0);
    wr(16'hff48, 8'h60, 1'b0, 1'b0);
    @(posedge mclk) halt_mode <= 1'b1;
    repeat (2000) @(posedge mclk);
    halt_mode <= 1'b0;
    stop_mode <= 1'b1;
    repeat (1000) @(posedge mclk);
    stop_mode <= 1'b0;
    // Pause of 3400 cycles, then 2048 slow ticks of 8 cycles
    wait_ovf(19700, 19900);
    $display("sleep test done");
    complete_run;
  end
endmodule
bind wdtc_watchdog wdtc_asserts i_chk (.mclk(mclk), .nrst(nrst), .opt_nonstop(opt_nonstop),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_bit_op(bus_bit_op),
  .bus_rd(bus_rd), .bus_rdata(bus_rdata), .wdt_reset_req(wdt_reset_req));

//--- wdtc_asserts.sv
// Port checker of the watchdog
`timescale 1ns/100ps
module wdtc_asserts (
  input wire        mclk,
  input wire        nrst,
  input wire        opt_nonstop,
  input wire [15:0] bus_addr,
  input wire [7:0]  bus_wdata,
  input wire        bus_wr,
  input wire        bus_bit_op,
  input wire        bus_rd,
  input wire [7:0]  bus_rdata,
  input wire        wdt_reset_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire wr_key  = bus_wr && bus_addr == 16'hff49;
  wire rd_mode = bus_rd && bus_addr == 16'hff48;
  a_rd_restart: assert property (
    bus_rd && bus_addr == 16'hff49 |=> bus_rdata == 8'h9a) else $error("bad restart read");
  a_mode_top: assert property (
    rd_mode |=> bus_rdata[7:5] == 3'h3) else $error("bad mode top bits");
  a_clk_fixed: assert property (
    rd_mode && opt_nonstop |=> bus_rdata[4:3] == 2'h0) else $error("clock bits not fixed");
  a_bad_key: assert property (
    wr_key && opt_nonstop && bus_wdata != 8'hac |=> wdt_reset_req) else $error("no reset");
  a_bit_op: assert property (
    wr_key && opt_nonstop && bus_bit_op |=> wdt_reset_req) else $error("no bit op reset");
  a_good_key: assert property (
    wr_key && !bus_bit_op && bus_wdata == 8'hac |=> !wdt_reset_req) else $error("key reset");
  a_req_pulse: assert property (
    $rose(wdt_reset_req) |=> $fell(wdt_reset_req)) else $error("request too long");
  a_rd_idle: assert property (
    !bus_rd |=> bus_rdata == 8'h00) else $error("read data not idle");
endmodule

//--- wdtc_map.vh
// Register map, field positions, reset values and timing counts of the watchdog
`ifndef WDTC_MAP_VH
`define WDTC_MAP_VH
`define WDTC_MODE_ADDR      16'hFF48
`define WDTC_RESTART_ADDR   16'hFF49
`define WDTC_MODE_RESET     8'h67
`define WDTC_MODE_LOW_RESET 5'h07
`define WDTC_RESTART_READ   8'h9A
`define WDTC_RESTART_KEY    8'hAC
`define WDTC_MODE_FIXED     3'h3
`define WDTC_PERIOD_MAX     3'h7
`define WDTC_CLK_LSB        3
`define WDTC_CLK_MSB        4
`define WDTC_STOP_TIME_NS   34000
`define WDTC_CLK_NS         10
`define WDTC_STOP_CYCLES    13'h0D48
`define WDTC_CNT_W          21
`define WDTC_LS_BASE_EXP    11
`define WDTC_SYS_BASE_EXP   13
`endif

//--- wdtc_tick_src.sv
// Oscillator model giving the watchdog a tick level
`timescale 1ns/100ps
module wdtc_tick_src #(parameter HALF = 4) (
  output reg  tick,
  input  wire mclk
);
  integer n = 0;
  initial tick = 1'b0;
  // Kept slower than a quarter of mclk so no edge is lost
  always @(posedge mclk) begin
    n <= (n == HALF - 1) ? 0 : n + 1;
    if (n == HALF - 1) tick <= ~tick;
  end
endmodule

//--- wdtc_watchdog.v
// Watchdog counter with mode and restart registers on the CPU data bus
`timescale 1ns/100ps
`include "wdtc_map.vh"
module wdtc_watchdog (
  input  wire       mclk,
  input  wire       nrst,
  input  wire       opt_nonstop,
  input  wire       low_speed_tick,
  input  wire       sys_tick,
  input  wire       halt_mode,
  input  wire       stop_mode,
  input  wire       osc_stable,
  input  wire       xtal_osc,
  input  wire [15:0] bus_addr,
  input  wire [7:0]  bus_wdata,
  input  wire       bus_wr,
  input  wire       bus_bit_op,
  input  wire       bus_rd,
  output reg  [7:0] bus_rdata,
  output reg        wdt_reset_req
);

// ----------------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------------
// Every pin here comes from another domain, so two flops come first
reg [6:0] s1;
reg [6:0] s2;
always @(posedge mclk) begin
  if (!nrst) begin
    s1 <= 7'h00;
    s2 <= 7'h00;
  end else begin
    s1 <= {opt_nonstop, low_speed_tick, sys_tick, halt_mode, stop_mode, osc_stable, xtal_osc};
    s2 <= s1;
  end
end
wire nonstop  = s2[6];
wire ls_lvl   = s2[5];
wire sys_lvl  = s2[4];
wire halt_s   = s2[3];
wire stop_s   = s2[2];
wire stable_s = s2[1];
wire xtal_s   = s2[0];

// Delayed copies reset low, the idle level of both ticks, so no false edge
wire [1:0] tick_lvl = {sys_lvl, ls_lvl};
wire [1:0] tick_edge;
genvar g;
generate
  for (g = 0; g < 2; g = g + 1) begin : g_edge
    reg lvl_d;
    always @(posedge mclk) begin
      if (!nrst) begin
        lvl_d <= 1'b0;
      end else begin
        lvl_d <= tick_lvl[g];
      end
    end
    assign tick_edge[g] = tick_lvl[g] & ~lvl_d;
  end
endgenerate
wire ls_en  = tick_edge[0];
wire sys_en = tick_edge[1];

// ----------------------------------------------------------------------
// Registers and access checks
// ----------------------------------------------------------------------
// Bits 7..5 are hard-wired, so only the five writable bits are stored
reg  [4:0] watchdog_mode_register;
reg        mode_written;
reg        wdt_disabled;

function wdtc_hit;
  input [15:0] addr;
  input [15:0] target;
  begin
    wdtc_hit = (addr == target);
  end
endfunction

wire mode_wr    = bus_wr & wdtc_hit(bus_addr, `WDTC_MODE_ADDR) & ~bus_bit_op;
wire mode_bitop = bus_wr & wdtc_hit(bus_addr, `WDTC_MODE_ADDR) & bus_bit_op;
wire rst_wr     = bus_wr & wdtc_hit(bus_addr, `WDTC_RESTART_ADDR);
wire rst_good   = rst_wr & ~bus_bit_op & (bus_wdata == `WDTC_RESTART_KEY);
wire period_sel_bit0 = watchdog_mode_register[0];
wire period_sel_bit1 = watchdog_mode_register[1];
wire period_sel_bit2 = watchdog_mode_register[2];
wire clock_sel_low   = watchdog_mode_register[`WDTC_CLK_LSB];
wire clock_sel_high  = watchdog_mode_register[`WDTC_CLK_MSB];

// Illegal accesses only count while the watchdog has not been stopped at first write
wire illegal = ~wdt_disabled & (((mode_wr | mode_bitop) & mode_written)
                              | (rst_wr & ~rst_good));

always @(posedge mclk) begin
  if (!nrst) begin
    watchdog_mode_register <= `WDTC_MODE_LOW_RESET;
    mode_written           <= 1'b0;
    wdt_disabled           <= 1'b0;
  end else if (mode_wr & ~mode_written) begin
    mode_written <= 1'b1;
    watchdog_mode_register[2:0] <= bus_wdata[2:0];
    if (nonstop) begin
      watchdog_mode_register[4:3] <= 2'b00;
    end else begin
      watchdog_mode_register[4:3] <= bus_wdata[4:3];
      wdt_disabled <= bus_wdata[`WDTC_CLK_MSB];
    end
  end
end

// ----------------------------------------------------------------------
// Read path
// ----------------------------------------------------------------------
// Read data stands one cycle only and is zero otherwise
always @(posedge mclk) begin
  if (!nrst) begin
    bus_rdata <= 8'h00;
  end else if (bus_rd && wdtc_hit(bus_addr, `WDTC_MODE_ADDR)) begin
    bus_rdata <= {`WDTC_MODE_FIXED, watchdog_mode_register};
  end else if (bus_rd && wdtc_hit(bus_addr, `WDTC_RESTART_ADDR)) begin
    bus_rdata <= `WDTC_RESTART_READ;
  end else begin
    bus_rdata <= 8'h00;
  end
end

// ----------------------------------------------------------------------
// Post-STOP pause
// ----------------------------------------------------------------------
reg        stop_d;
reg [12:0] pause_cnt;
reg        wait_osc;
wire       use_sys = ~nonstop & ~clock_sel_high & clock_sel_low;
// Counts as paused already in the cycle the release is seen, so no tick slips in
wire       stop_fall = stop_d & ~stop_s & ~nonstop;
// Ticks that land in the pause are dropped, not queued
always @(posedge mclk) begin
  if (!nrst) begin
    stop_d    <= 1'b0;
    pause_cnt <= 13'h0000;
    wait_osc  <= 1'b0;
  end else begin
    stop_d <= stop_s;
    if (stop_fall) begin
      pause_cnt <= `WDTC_STOP_CYCLES;
      wait_osc  <= use_sys & xtal_s;
    end else if (pause_cnt != 13'h0000) begin
      pause_cnt <= pause_cnt - 13'h0001;
    end else if (wait_osc & stable_s) begin
      wait_osc <= 1'b0;
    end
  end
end
wire paused = (pause_cnt != 13'h0000) | wait_osc | stop_fall;

// ----------------------------------------------------------------------
// Counter and overflow
// ----------------------------------------------------------------------
// Highest count before the wrap; one more tick overflows
function [20:0] wdtc_limit;
  input [2:0] sel;
  input       sys;
  begin
    wdtc_limit = (21'h00_0001 << (sel + (sys ? `WDTC_SYS_BASE_EXP : `WDTC_LS_BASE_EXP)))
                 - 21'h00_0001;
  end
endfunction

reg  [20:0] count;
reg  [20:0] next_count;
reg         next_req;
// Non-stoppable mode ignores HALT/STOP; stoppable holds count there
wire sleep = ~nonstop & (halt_s | stop_s | paused);
wire tick  = use_sys ? sys_en : ls_en;
wire run   = (nonstop | ~clock_sel_high) & ~sleep & tick;
wire [20:0] limit = wdtc_limit({period_sel_bit2, period_sel_bit1, period_sel_bit0}, use_sys);

wire clear = mode_wr | rst_good;
wire wrap  = run & (count == limit);

// A restart on the overflow tick wins: software met its deadline in time
always @* begin
  next_count = count;
  next_req   = illegal;
  if (clear) begin
    next_count = 21'h00_0000;
  end else if (wrap) begin
    next_count = 21'h00_0000;
    next_req   = 1'b1;
  end else if (run) begin
    next_count = count + 21'h00_0001;
  end
end

always @(posedge mclk) begin
  if (!nrst) begin
    count         <= 21'h00_0000;
    wdt_reset_req <= 1'b0;
  end else begin
    count         <= next_count;
    wdt_reset_req <= next_req;
  end
end

endmodule
